// File: rtl/dsr_param_mem.sv
`timescale 1ns/100ps
module dsr_param_mem #(
  parameter int DEPTH  = 512,
  parameter int AWIDTH = 9
) (
  input  wire logic              i_clock,
  input  wire logic              i_wr,
  input  wire logic [AWIDTH-1:0] i_waddr,
  input  wire logic [15:0]       i_wdata,
  input  wire logic [AWIDTH-1:0] i_raddr,
  output logic      [15:0]       o_rdata
);

  logic [15:0] mem [DEPTH];
  logic [15:0] rdata_ff;

  always_ff @(posedge i_clock) begin
    if (i_wr) begin
      mem[i_waddr] <= i_wdata;
    end
    rdata_ff <= mem[i_raddr];
  end

  assign o_rdata = rdata_ff;

endmodule

// File: rtl/dsr_pkg.sv
package dsr_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [15:0] ADDR_RO_LOW_FIRST  = 16'h03E8;
  localparam logic [15:0] ADDR_RO_LOW_LAST   = 16'h0567;
  localparam logic [15:0] ADDR_RW_FIRST      = 16'h0568;
  localparam logic [15:0] ADDR_RW_LAST       = 16'h05A7;
  localparam logic [15:0] ADDR_RO_HIGH_FIRST = 16'h05A8;
  localparam logic [15:0] ADDR_RO_HIGH_LAST  = 16'h05E7;
  localparam logic [15:0] ADDR_CONTROL_WORD  = 16'h07D0;

  localparam logic [15:0] CONTROL_WORD_RESET = 16'h0000;
  localparam logic [15:0] DATA_ZERO          = 16'h0000;

  // ------------------------------------------------------------
  // control word fields
  // ------------------------------------------------------------
  localparam int BIT_FAULT_CLEAR = 1;
  localparam int BIT_FORCE_PID   = 4;
  localparam int BIT_FORCE_FREQ  = 5;
  localparam int BIT_FORCE_START = 6;
  localparam int BIT_BLOCK_CFG   = 12;
  localparam int BIT_BLOCK_RAMP  = 13;
  localparam int BIT_BLOCK_COAST = 14;
  localparam int BIT_START       = 15;

  // ------------------------------------------------------------
  // permission setting, stop methods and fault clear states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PERM_DISABLED = 2'h0,
    PERM_ENABLED  = 2'h1,
    PERM_DIGITAL  = 2'h2
  } dsr_perm_t;

  typedef enum logic [1:0] {
    STOP_NONE  = 2'h0,
    STOP_RAMP  = 2'h1,
    STOP_COAST = 2'h2
  } dsr_stop_t;

  typedef enum logic [2:0] {
    CLR_IDLE = 3'b001,
    CLR_LOW  = 3'b010,
    CLR_HIGH = 3'b100
  } dsr_clr_state_t;

  // register access request from the serial protocol engine
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dsr_req_t;

  // drive control outcome
  typedef struct packed {
    logic      sel_pid_serial;
    logic      sel_freq_serial;
    logic      sel_start_serial;
    logic      freq_ref_zero;
    logic      run;
    dsr_stop_t stop_method;
  } dsr_drive_t;

endpackage

// File: rtl/dsr_register_map.sv
`timescale 1ns/100ps
// Overview of operation
// - entries 0..383 at addresses 1000..1383, serial reads only
// - entries 384..447 at addresses 1384..1447, serial read and write
// - entries 448..511 at addresses 1448..1511, serial reads only
// - control word at 2000 acts only while serial permission is granted
// - bit 1 low-high-low sequence clears the latched fault
// - bit 4 forces PID reference from serial register
// - bit 5 forces frequency reference from serial register
// - bit 6 forces start and stop from serial link
// - forcing disconnects the configured source of that function
// - source already configured serial follows serial without forcing bit
// - bit 12 blocks, stopping by configured stop method
// - bit 13 blocks, stopping along deceleration ramp
// - bit 14 blocks, removing drive so motor coasts
// - bit 15 starts when 1, stops when 0, under serial start control
// - any blocking bit blocks regardless of control source
// - bits 0, 2, 3, 7..11 have no function
// - registers are 16 bits; unmapped addresses are unsupported
// - permission is enabled, disabled, or taken from a digital input
// - serial source without permission: stay stopped, frequency reference zero
module dsr_register_map (
  input  wire logic               i_clock,
  input  wire logic               i_srst,
  input  wire dsr_pkg::dsr_req_t  i_req,
  input  wire dsr_pkg::dsr_perm_t i_perm_mode,
  input  wire logic               i_perm_input,
  input  wire logic               i_cfg_pid_serial,
  input  wire logic               i_cfg_freq_serial,
  input  wire logic               i_cfg_start_serial,
  input  wire logic               i_local_run,
  input  wire dsr_pkg::dsr_stop_t i_cfg_stop_method,
  input  wire logic               i_fault_set,
  input  wire logic               i_int_wr,
  input  wire logic [8:0]         i_int_addr,
  input  wire logic [15:0]        i_int_wdata,
  output logic                    o_rvalid,
  output logic [15:0]             o_rdata,
  output logic                    o_exception,
  output logic                    o_fault,
  output dsr_pkg::dsr_drive_t     o_drive,
  output logic [15:0]             o_rw_entry_data,
  output logic [8:0]              o_rw_entry_addr,
  output logic                    o_rw_entry_wr
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic        hit_ro_low;
  logic        hit_rw;
  logic        hit_ro_high;
  logic        hit_ctrl;
  logic        hit_param;
  logic [15:0] param_off;
  logic [8:0]  param_idx;

  always_comb begin
    hit_ro_low  = (i_req.addr >= dsr_pkg::ADDR_RO_LOW_FIRST) &&
                  (i_req.addr <= dsr_pkg::ADDR_RO_LOW_LAST);
    hit_rw      = (i_req.addr >= dsr_pkg::ADDR_RW_FIRST) &&
                  (i_req.addr <= dsr_pkg::ADDR_RW_LAST);
    hit_ro_high = (i_req.addr >= dsr_pkg::ADDR_RO_HIGH_FIRST) &&
                  (i_req.addr <= dsr_pkg::ADDR_RO_HIGH_LAST);
    hit_ctrl    = (i_req.addr == dsr_pkg::ADDR_CONTROL_WORD);
    hit_param   = hit_ro_low || hit_rw || hit_ro_high;
    param_off   = i_req.addr - dsr_pkg::ADDR_RO_LOW_FIRST;
    param_idx   = param_off[8:0];
  end

  // ------------------------------------------------------------
  // parameter channel store
  // ------------------------------------------------------------
  logic        serial_entry_wr;
  logic        mem_wr;
  logic [8:0]  mem_waddr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;

  always_comb begin
    serial_entry_wr = i_req.wr && hit_rw;
    mem_wr          = serial_entry_wr || i_int_wr;
    mem_waddr       = serial_entry_wr ? param_idx : i_int_addr;
    mem_wdata       = serial_entry_wr ? i_req.wdata : i_int_wdata;
  end

  dsr_param_mem #(
    .DEPTH  (512),
    .AWIDTH (9)
  ) u_mem (
    .i_clock (i_clock),
    .i_wr    (mem_wr),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_raddr (param_idx),
    .o_rdata (mem_rdata)
  );

  // ------------------------------------------------------------
  // control word and read path
  // ------------------------------------------------------------
  logic [15:0] ctrl_ff;
  logic [15:0] nxt_ctrl;
  logic        rd_param_ff;
  logic        nxt_rd_param;
  logic        rvalid_ff;
  logic        nxt_rvalid;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic        exc_ff;
  logic        nxt_exc;
  logic        ewr_ff;
  logic        nxt_ewr;
  logic [8:0]  eaddr_ff;
  logic [8:0]  nxt_eaddr;
  logic [15:0] edata_ff;
  logic [15:0] nxt_edata;

  always_comb begin
    nxt_ctrl     = ctrl_ff;
    nxt_rd_param = 1'b0;
    nxt_rvalid   = 1'b0;
    nxt_rdata    = dsr_pkg::DATA_ZERO;
    nxt_exc      = 1'b0;
    nxt_ewr      = serial_entry_wr;
    nxt_eaddr    = serial_entry_wr ? param_idx : eaddr_ff;
    nxt_edata    = serial_entry_wr ? i_req.wdata : edata_ff;
    if (i_req.wr) begin
      if (hit_ctrl) begin
        nxt_ctrl = i_req.wdata;
      end else if (!hit_rw) begin
        nxt_exc = 1'b1;
      end
    end else if (i_req.rd) begin
      if (hit_ctrl) begin
        nxt_rvalid = 1'b1;
        nxt_rdata  = ctrl_ff;
      end else if (hit_param) begin
        nxt_rd_param = 1'b1;
      end else begin
        nxt_exc = 1'b1;
      end
    end
    if (rd_param_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = mem_rdata;
    end
    if (i_srst) begin
      nxt_ctrl = dsr_pkg::CONTROL_WORD_RESET;
    end
  end

  always_ff @(posedge i_clock) begin
    ctrl_ff     <= nxt_ctrl;
    rd_param_ff <= i_srst ? 1'b0 : nxt_rd_param;
    rvalid_ff   <= i_srst ? 1'b0 : nxt_rvalid;
    rdata_ff    <= i_srst ? dsr_pkg::DATA_ZERO : nxt_rdata;
    exc_ff      <= i_srst ? 1'b0 : nxt_exc;
    ewr_ff      <= i_srst ? 1'b0 : nxt_ewr;
    eaddr_ff    <= i_srst ? 9'h000 : nxt_eaddr;
    edata_ff    <= i_srst ? dsr_pkg::DATA_ZERO : nxt_edata;
  end

  // ------------------------------------------------------------
  // permission and control decoding
  // ------------------------------------------------------------
  logic               permitted;
  logic [15:0]        eff_ctrl;
  logic               blocked;
  logic               sel_pid;
  logic               sel_freq;
  logic               sel_start;
  logic               run_cmd;
  dsr_pkg::dsr_stop_t stop_how;

  always_comb begin
    case (i_perm_mode)
      dsr_pkg::PERM_ENABLED: permitted = 1'b1;
      dsr_pkg::PERM_DIGITAL: permitted = i_perm_input;
      default:               permitted = 1'b0;
    endcase
    // bits 0, 2, 3 and 7..11 feed nothing below
    eff_ctrl  = permitted ? ctrl_ff : dsr_pkg::DATA_ZERO;
    blocked   = eff_ctrl[dsr_pkg::BIT_BLOCK_CFG] ||
                eff_ctrl[dsr_pkg::BIT_BLOCK_RAMP] ||
                eff_ctrl[dsr_pkg::BIT_BLOCK_COAST];
    sel_pid   = eff_ctrl[dsr_pkg::BIT_FORCE_PID] || i_cfg_pid_serial;
    sel_freq  = eff_ctrl[dsr_pkg::BIT_FORCE_FREQ] || i_cfg_freq_serial;
    sel_start = eff_ctrl[dsr_pkg::BIT_FORCE_START] || i_cfg_start_serial;
    if (sel_start) begin
      run_cmd = permitted && eff_ctrl[dsr_pkg::BIT_START];
    end else begin
      run_cmd = i_local_run;
    end
    if (eff_ctrl[dsr_pkg::BIT_BLOCK_COAST]) begin
      stop_how = dsr_pkg::STOP_COAST;
    end else if (eff_ctrl[dsr_pkg::BIT_BLOCK_RAMP]) begin
      stop_how = dsr_pkg::STOP_RAMP;
    end else begin
      stop_how = i_cfg_stop_method;
    end
  end

  // ------------------------------------------------------------
  // drive outcome register
  // ------------------------------------------------------------
  dsr_pkg::dsr_drive_t drive_ff;
  dsr_pkg::dsr_drive_t nxt_drive;

  always_comb begin
    nxt_drive.sel_pid_serial   = sel_pid;
    nxt_drive.sel_freq_serial  = sel_freq;
    nxt_drive.sel_start_serial = sel_start;
    nxt_drive.freq_ref_zero    = sel_freq && !permitted;
    nxt_drive.run              = run_cmd && !blocked;
    nxt_drive.stop_method      = stop_how;
    if (i_srst) begin
      nxt_drive = '0;
    end
  end

  always_ff @(posedge i_clock) begin
    drive_ff <= nxt_drive;
  end

  // ------------------------------------------------------------
  // fault clear sequence
  // ------------------------------------------------------------
  dsr_pkg::dsr_clr_state_t clr_ff;
  dsr_pkg::dsr_clr_state_t nxt_clr;
  logic                    fault_ff;
  logic                    nxt_fault;
  logic                    clr_done;

  always_comb begin
    nxt_clr  = clr_ff;
    clr_done = 1'b0;
    case (clr_ff)
      dsr_pkg::CLR_IDLE: begin
        if (!eff_ctrl[dsr_pkg::BIT_FAULT_CLEAR]) begin
          nxt_clr = dsr_pkg::CLR_LOW;
        end
      end
      dsr_pkg::CLR_LOW: begin
        if (eff_ctrl[dsr_pkg::BIT_FAULT_CLEAR]) begin
          nxt_clr = dsr_pkg::CLR_HIGH;
        end
      end
      dsr_pkg::CLR_HIGH: begin
        if (!eff_ctrl[dsr_pkg::BIT_FAULT_CLEAR]) begin
          nxt_clr  = dsr_pkg::CLR_LOW;
          clr_done = 1'b1;
        end
      end
      default: begin
        nxt_clr = dsr_pkg::CLR_IDLE;
      end
    endcase
    nxt_fault = clr_done ? 1'b0 : fault_ff;
    // a new failure in the clearing cycle wins
    if (i_fault_set) begin
      nxt_fault = 1'b1;
    end
    if (i_srst) begin
      nxt_clr   = dsr_pkg::CLR_IDLE;
      nxt_fault = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    clr_ff   <= nxt_clr;
    fault_ff <= nxt_fault;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_rvalid        = rvalid_ff;
  assign o_rdata         = rdata_ff;
  assign o_exception     = exc_ff;
  assign o_fault         = fault_ff;
  assign o_drive         = drive_ff;
  assign o_rw_entry_data = edata_ff;
  assign o_rw_entry_addr = eaddr_ff;
  assign o_rw_entry_wr   = ewr_ff;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb_chk @(posedge i_clock);
  endclocking
  default disable iff (i_srst);

  sequence s_clr_high;
    clr_ff == dsr_pkg::CLR_HIGH;
  endsequence
  sequence s_clr_release;
    !eff_ctrl[dsr_pkg::BIT_FAULT_CLEAR] && !i_fault_set;
  endsequence
  property p_fault_clear;
    s_clr_high ##0 s_clr_release |=> !o_fault;
  endproperty

  chk_fault_clear: assert property (p_fault_clear)
    else $error("fault not cleared after low-high-low");
  chk_fault_set_wins: assert property (i_fault_set |=> o_fault)
    else $error("fault event lost");
  chk_ro_write_refused: assert property (i_req.wr && (hit_ro_low || hit_ro_high) |=> o_exception)
    else $error("write to read-only entry not refused");
  chk_rw_write_lands: assert property (serial_entry_wr |=> o_rw_entry_wr &&
      (o_rw_entry_addr == $past(param_idx)))
    else $error("writable entry not reported");
  chk_ctrl_readback: assert property (i_req.rd && !i_req.wr && hit_ctrl |=> o_rvalid &&
      (o_rdata == $past(ctrl_ff)))
    else $error("control word read back wrong");
  chk_unmapped_access: assert property ((i_req.rd || i_req.wr) && !hit_param && !hit_ctrl
      |=> o_exception)
    else $error("unmapped access not refused");
  chk_block_stops: assert property (blocked |=> !o_drive.run)
    else $error("blocked drive still running");
  chk_coast_method: assert property (eff_ctrl[dsr_pkg::BIT_BLOCK_COAST]
      |=> o_drive.stop_method == dsr_pkg::STOP_COAST)
    else $error("coast block gives wrong stop method");
  chk_no_permission_stop: assert property (!permitted && i_cfg_start_serial |=> !o_drive.run)
    else $error("runs without serial permission");

endmodule

// File: testbench/drive_serial_register_map_tb.sv
`timescale 1ns/100ps
module drive_serial_register_map_tb;
  logic clk, srst, pin, cpid, cfrq, cst, fset, iwr, rv, ex, flt, ewr, lrun;
  logic [8:0] iad, ead;
  logic [15:0] iwd, rdat, ed, q;
  logic e;
  dsr_pkg::dsr_req_t req;
  dsr_pkg::dsr_perm_t pm;
  dsr_pkg::dsr_stop_t sm;
  dsr_pkg::dsr_drive_t drv;
  int mismatches = 0;
  int check_count = 0;
  dsr_master_model mm (.i_clock(clk), .i_rvalid(rv), .i_exception(ex), .i_rdata(rdat),
    .o_req(req));
  dsr_register_map dut (.i_clock(clk), .i_srst(srst), .i_req(req), .i_perm_mode(pm),
    .i_perm_input(pin), .i_cfg_pid_serial(cpid), .i_cfg_freq_serial(cfrq),
    .i_cfg_start_serial(cst), .i_local_run(lrun), .i_cfg_stop_method(sm),
    .i_fault_set(fset), .i_int_wr(iwr), .i_int_addr(iad), .i_int_wdata(iwd),
    .o_rvalid(rv), .o_rdata(rdat), .o_exception(ex), .o_fault(flt), .o_drive(drv),
    .o_rw_entry_data(ed), .o_rw_entry_addr(ead), .o_rw_entry_wr(ewr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk16(input logic [15:0] g, input logic [15:0] x);
    check_count++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic chk1(input logic g, input logic x);
    chk16({15'h0000, g}, {15'h0000, x});
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    mm.xfer(1'b0, a, d, q, e);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    mm.xfer(1'b1, a, 16'h0000, q, e);
  endtask
  task automatic load(input logic [8:0] a, input logic [15:0] d);
    iwr = 1'b1;
    iad = a;
    iwd = d;
    @(posedge clk);
    #1;
    iwr = 1'b0;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_windows();
    wr(16'h0568, 16'hA5C3);
    chk16({7'h00, ead}, 16'h0180);
    chk16(ed, 16'hA5C3);
    rd(16'h0568);
    chk16(q, 16'hA5C3);
    load(9'h000, 16'h0F0F);
    load(9'h1FF, 16'h3C3C);
    wr(16'h03E8, 16'hFFFF);
    wr(16'h05E7, 16'hFFFF);
    rd(16'h03E8);
    chk16(q, 16'h0F0F);
    rd(16'h05E7);
    chk16(q, 16'h3C3C);
    rd(16'h07CF);
    chk1(e, 1'b1);
  endtask
  task automatic t_control();
    wr(16'h07D0, 16'h8FCD);
    chk1(drv.run, 1'b1);
    rd(16'h07D0);
    chk16(q, 16'h8FCD);
    sm = dsr_pkg::STOP_COAST;
    wr(16'h07D0, 16'hA040);
    chk1(drv.run, 1'b0);
    chk16(16'(drv.stop_method), 16'(dsr_pkg::STOP_RAMP));
    sm = dsr_pkg::STOP_RAMP;
    wr(16'h07D0, 16'hC040);
    chk1(drv.run, 1'b0);
    chk16(16'(drv.stop_method), 16'(dsr_pkg::STOP_COAST));
    wr(16'h07D0, 16'h9040);
    chk1(drv.run, 1'b0);
    chk16(16'(drv.stop_method), 16'(dsr_pkg::STOP_RAMP));
    lrun = 1'b1;
    wr(16'h07D0, 16'h0030);
    chk1(drv.sel_pid_serial & drv.sel_freq_serial, 1'b1);
    chk1(drv.sel_start_serial, 1'b0);
    chk1(drv.run, 1'b1);
    wr(16'h07D0, 16'h0040);
    chk1(drv.run, 1'b0);
    lrun = 1'b0;
  endtask
  task automatic t_perm();
    cst = 1'b1;
    wr(16'h07D0, 16'h8000);
    chk1(drv.run, 1'b1);
    pm = dsr_pkg::PERM_DISABLED;
    cfrq = 1'b1;
    wr(16'h07D0, 16'h8040);
    chk1(drv.run, 1'b0);
    chk1(drv.freq_ref_zero, 1'b1);
    pm = dsr_pkg::PERM_DIGITAL;
    pin = 1'b1;
    wr(16'h07D0, 16'h8040);
    chk1(drv.run, 1'b1);
    cpid = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk1(drv.sel_pid_serial, 1'b1);
    pin = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk1(drv.run, 1'b0);
  endtask
  task automatic t_fault();
    fset = 1'b1;
    @(posedge clk);
    #1;
    fset = 1'b0;
    wr(16'h07D0, 16'h0000);
    wr(16'h07D0, 16'h0002);
    chk1(flt, 1'b1);
    wr(16'h07D0, 16'h0000);
    chk1(flt, 1'b0);
  endtask
  task automatic summarize();
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {pin, cpid, cfrq, cst, fset, iwr, iad, iwd, lrun} = '0;
    srst = 1'b1;
    pm = dsr_pkg::PERM_ENABLED;
    sm = dsr_pkg::STOP_COAST;
    repeat (8) @(posedge clk);
    #1;
    srst = 1'b0;
    t_windows();
    t_control();
    t_fault();
    t_perm();
    summarize();
  end
  initial begin
    #(1000 * 100);
    mismatches++;
    summarize();
  end
endmodule

// File: testbench/dsr_master_model.sv
`timescale 1ns/100ps
module dsr_master_model (
  input  wire logic          i_clock,
  input  wire logic          i_rvalid,
  input  wire logic          i_exception,
  input  wire logic [15:0]   i_rdata,
  output dsr_pkg::dsr_req_t  o_req
);
  initial o_req = '0;
  // one request held for one edge, answer awaited a bounded time
  task automatic xfer(input logic rd, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic e);
    q = 16'hXXXX;
    e = 1'b0;
    o_req = '{rd: rd, wr: !rd, addr: a, wdata: d};
    @(posedge i_clock);
    #1;
    o_req = '0;
    for (int n = 0; n < 4; n++) begin
      if (i_rvalid || i_exception) begin
        q = i_rdata;
        e = i_exception;
      end
      @(posedge i_clock);
      #1;
    end
  endtask
endmodule
